// [rtl/acr_cfg.svh]
// audio clock rate block: offsets, field positions, resets and timing
// assumes inclusion by bare name from the package and the design files
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// register offsets on the control port
`define ACR_OFF_CLKDIV 8'h03
`define ACR_OFF_OSR 8'h29
`define ACR_OFF_SRATE 8'h40

// clock_divider_select fields
`define ACR_POST_LSB 0
`define ACR_PRE_LSB 4
`define ACR_MULT_LSB 8
`define ACR_DACDIV_LSB 12
// dac_oversample_select field
`define ACR_OSR_LSB 0
// sample_rate_range field and read-only status nibble
`define ACR_SRATE_LSB 0
`define ACR_STAT_LSB 12

// reset values
`define ACR_CLKDIV_RST 16'h0011
`define ACR_OSR_RST 16'h0000
`define ACR_SRATE_RST 16'h0002

// supported system clock to frame ratios and fixed rates
`define ACR_RATIO_A 10'd256
`define ACR_RATIO_B 10'd400
`define ACR_RATIO_C 10'd500
`define ACR_OSR_FIXED 9'd100
`define ACR_MIN_BCLK 5'd8

// timing: clock period and presence detector figures
`define ACR_CLK_NS 8
`define ACR_ATTACK_NS 1000
`define ACR_RELEASE_NS 50000
`define ACR_ATTACK_CYC (`ACR_ATTACK_NS / `ACR_CLK_NS)
`define ACR_RELEASE_CYC ((`ACR_RELEASE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)

`endif

// [rtl/acr_pkg.sv]
// audio clock rate block: shared types
// assumes acr_cfg.svh sits on the include path
`include "acr_cfg.svh"

package acr_pkg;

	// detected system clock to frame ratio
	typedef enum logic [1:0] {
		RATIO_NONE,
		RATIO_256,
		RATIO_400,
		RATIO_500
	} acr_ratio_e;

	// effective dac clock divide
	typedef enum logic [2:0] {
		DIV_1,
		DIV_2,
		DIV_4,
		DIV_8,
		DIV_5
	} acr_div_e;

	// decoded clock configuration
	typedef struct packed {
		logic [2:0] pre_divider;
		logic [2:0] post_divider;
		logic [2:0] mult_sel;
		logic [1:0] dac_div_sel;
		logic [1:0] osr_sel;
	} acr_cfg_s;

	// detector state shown to the rest of the chip
	typedef struct packed {
		logic master_clock_present;
		logic bclk_ok;
		acr_ratio_e ratio;
	} acr_stat_s;

endpackage : acr_pkg

// [rtl/acr_sysdiv.sv]
// fractional system clock generator: counts system clock edges
// assumes mclk_edge is a one-cycle pulse already in the ref_clk domain
`timescale 1ns/1ps

module acr_sysdiv (
	input wire logic ref_clk, // core clock
	input wire logic reset, // sync reset, active high
	input wire logic mclk_edge, // one pulse per master clock rising edge
	input wire logic [3:0] num, // multiplier numerator
	input wire logic [5:0] den, // divider denominator, never zero
	output logic [3:0] sys_ticks // system clock edges at this mclk edge
);

	logic [5:0] acc_r;
	logic [6:0] sum;
	logic [6:0] ticks;

	// remainder carries between edges so the long-run rate is exact
	assign sum = {1'b0, acc_r} + {3'b000, num};
	assign ticks = sum / {1'b0, den};

	// accumulator keeps running whatever the detect mode is
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			acc_r <= 6'h00;
			sys_ticks <= 4'h0;
		end else if (mclk_edge) begin
			acc_r <= 6'(sum - 7'(ticks * {1'b0, den}));
			sys_ticks <= ticks[3:0];
		end else begin
			sys_ticks <= 4'h0;
		end
	end

endmodule : acr_sysdiv

// [rtl/acr_top.sv]
// audio clock rate block: control registers, clock detect and rate select
// assumes mclk, bclk and fsync are pins and the bypass comes from logic
`timescale 1ns/1ps
`include "acr_cfg.svh"

module acr_top #(
	parameter int RELEASE_CYC = `ACR_RELEASE_CYC // mclk loss timeout
) (
	input wire logic ref_clk, // core clock, 125 MHz
	input wire logic reset, // sync reset, active high
	input wire logic mclk, // master clock pin
	input wire logic bclk, // bit clock pin
	input wire logic fsync, // frame sync pin
	input wire logic clock_detect_bypass, // 1 forces power-up
	input wire logic [7:0] reg_addr, // control register offset
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [15:0] reg_wdata, // write data
	output logic [15:0] reg_rdata, // read data, next cycle
	output logic auto_power_up, // analog power-up request
	output logic clock_loss_shutdown, // driver shutdown
	output acr_pkg::acr_stat_s status, // detector state
	output logic [8:0] dac_osr, // effective oversampling rate
	output acr_pkg::acr_div_e dac_div, // effective dac divide
	output logic [2:0] rate_range, // sample rate range field
	output logic [3:0] sys_ticks // system clock edges per ref_clk
);

	localparam int ATTACK_CYC = `ACR_ATTACK_CYC;

	logic [15:0] clkdiv_r, osr_r, srate_r;
	acr_pkg::acr_cfg_s cfg;
	logic [2:0] mclk_s, bclk_s, fs_s;
	logic mclk_edge, bclk_edge, fs_edge;
	logic [12:0] gap_r;
	logic present_r;
	logic [3:0] num;
	logic [5:0] den;
	logic [9:0] frame_r;
	logic [4:0] bcnt_r;
	logic bclk_ok_r;
	acr_pkg::acr_ratio_e ratio_r;

	// the ratio a frame count stands for, or none
	function automatic acr_pkg::acr_ratio_e ratio_of(input logic [9:0] c);
		if (c == `ACR_RATIO_A)
			return acr_pkg::RATIO_256;
		else if (c == `ACR_RATIO_B)
			return acr_pkg::RATIO_400;
		else if (c == `ACR_RATIO_C)
			return acr_pkg::RATIO_500;
		else
			return acr_pkg::RATIO_NONE;
	endfunction : ratio_of

	// oversampling rate selected by the dac_oversample_select field
	function automatic logic [8:0] osr_of(input logic [1:0] s);
		return 9'(9'd32 << s);
	endfunction : osr_of

	// divider codes of zero behave as one
	function automatic logic [2:0] nz(input logic [2:0] v);
		return (v == 3'd0) ? 3'd1 : v;
	endfunction : nz

	// register writes; unmapped offsets are ignored
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			clkdiv_r <= `ACR_CLKDIV_RST;
			osr_r <= `ACR_OSR_RST;
			srate_r <= `ACR_SRATE_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ACR_OFF_CLKDIV: clkdiv_r <= reg_wdata;
				`ACR_OFF_OSR: osr_r <= reg_wdata;
				`ACR_OFF_SRATE: srate_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// reads; the top nibble of the range register shows live status
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ACR_OFF_CLKDIV: reg_rdata <= clkdiv_r;
				`ACR_OFF_OSR: reg_rdata <= osr_r;
				`ACR_OFF_SRATE: reg_rdata <= {present_r, bclk_ok_r,
					ratio_r, srate_r[11:0]};
				default: reg_rdata <= 16'h0000;
			endcase
		end
	end

	assign cfg.post_divider = clkdiv_r[`ACR_POST_LSB +: 3];
	assign cfg.pre_divider = clkdiv_r[`ACR_PRE_LSB +: 3];
	assign cfg.mult_sel = clkdiv_r[`ACR_MULT_LSB +: 3];
	assign cfg.dac_div_sel = clkdiv_r[`ACR_DACDIV_LSB +: 2];
	assign cfg.osr_sel = osr_r[`ACR_OSR_LSB +: 2];
	assign rate_range = srate_r[`ACR_SRATE_LSB +: 3];

	// pins pass two flops; the third flop only feeds edge detection
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			mclk_s <= 3'h0;
			bclk_s <= 3'h0;
			fs_s <= 3'h0;
		end else begin
			mclk_s <= {mclk_s[1:0], mclk};
			bclk_s <= {bclk_s[1:0], bclk};
			fs_s <= {fs_s[1:0], fsync};
		end
	end
	assign mclk_edge = mclk_s[1] & ~mclk_s[2];
	assign bclk_edge = bclk_s[1] & ~bclk_s[2];
	assign fs_edge = fs_s[1] & ~fs_s[2];

	// presence attack and release
	// two edges inside the attack window set it, silence clears it
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gap_r <= 13'h1FFF;
			present_r <= 1'b0;
		end else if (mclk_edge) begin
			gap_r <= 13'h0000;
			if (gap_r < 13'(ATTACK_CYC))
				present_r <= 1'b1;
		end else begin
			if (gap_r != 13'h1FFF)
				gap_r <= gap_r + 13'h0001;
			if (gap_r >= 13'(RELEASE_CYC - 1))
				present_r <= 1'b0;
		end
	end

	// multiply then divide by both dividers, or by the post divider alone for code 0
	// codes 1..4 give factors 1, 2, 4, 8
	always_comb begin
		if (cfg.mult_sel == 3'd0) begin
			num = 4'd1;
			den = {3'b000, nz(cfg.post_divider)};
		end else begin
			num = (cfg.mult_sel >= 3'd4) ? 4'd8 :
				4'(4'd1 << (cfg.mult_sel - 3'd1));
			den = 6'(nz(cfg.pre_divider) * nz(cfg.post_divider));
		end
	end

	// dividers run with or without bypass
	acr_sysdiv u_sysdiv (
		.ref_clk(ref_clk),
		.reset(reset),
		.mclk_edge(mclk_edge),
		.num(num),
		.den(den),
		.sys_ticks(sys_ticks)
	);

	// system ticks per frame, judged at each frame edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			frame_r <= 10'h000;
			ratio_r <= acr_pkg::RATIO_NONE;
		end else if (!present_r) begin
			frame_r <= 10'h000;
			ratio_r <= acr_pkg::RATIO_NONE;
		end else if (fs_edge) begin
			frame_r <= 10'(sys_ticks);
			ratio_r <= ratio_of(frame_r);
		end else if (frame_r < 10'h3F0) begin
			frame_r <= frame_r + 10'(sys_ticks);
		end
	end

	// bit clocks per frame; saturates so long frames stay valid
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bcnt_r <= 5'h00;
			bclk_ok_r <= 1'b0;
		end else if (fs_edge) begin
			bclk_ok_r <= (bcnt_r >= `ACR_MIN_BCLK);
			bcnt_r <= {4'h0, bclk_edge};
		end else if (bclk_edge && bcnt_r != 5'h1F) begin
			bcnt_r <= bcnt_r + 5'h01;
		end
	end

	assign status = '{present_r, bclk_ok_r, ratio_r};

	// power control and clock loss protection
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			auto_power_up <= 1'b0;
			clock_loss_shutdown <= 1'b0;
		end else begin
			auto_power_up <= clock_detect_bypass | (present_r & bclk_ok_r &
				(ratio_r != acr_pkg::RATIO_NONE));
			clock_loss_shutdown <= ~clock_detect_bypass & ~present_r;
		end
	end

	// dac rate: 400 and 500 force oversampling 100, 500 also forces divide by five; other ratios obey software
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dac_osr <= 9'd32;
			dac_div <= acr_pkg::DIV_1;
		end else begin
			dac_osr <= osr_of(cfg.osr_sel);
			dac_div <= acr_pkg::acr_div_e'({1'b0, cfg.dac_div_sel});
			if (ratio_r == acr_pkg::RATIO_400 ||
				ratio_r == acr_pkg::RATIO_500)
				dac_osr <= `ACR_OSR_FIXED;
			if (ratio_r == acr_pkg::RATIO_500)
				dac_div <= acr_pkg::DIV_5;
		end
	end

	bypass_pwr_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		$past(clock_detect_bypass) |-> auto_power_up)
		else $error("power-up low during bypass");

	div_bypass_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		clock_detect_bypass && mclk_edge && num >= 4'(den) && den < 6'd9
		|=> sys_ticks != 4'h0)
		else $error("divider idle during bypass");

	direct_div_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		mclk_edge && cfg.mult_sel == 3'd0 && cfg.post_divider == 3'd1
		|=> sys_ticks == 4'h1)
		else $error("direct divide wrong");

	mult_eight_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		mclk_edge && cfg.mult_sel == 3'd4 && den == 6'd1
		|=> sys_ticks == 4'h8)
		else $error("factor eight not applied");

	osr_field_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		ratio_r == acr_pkg::RATIO_256 |=> dac_osr == osr_of($past(cfg.osr_sel)))
		else $error("oversampling not from field");

	osr_fixed_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		ratio_r == acr_pkg::RATIO_400 |=> dac_osr == 9'd100)
		else $error("oversampling not 100");

	div_fifth_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		ratio_r == acr_pkg::RATIO_500 |=> dac_div == acr_pkg::DIV_5)
		else $error("divide by five missing");

	loss_stop_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		$fell(present_r) && !clock_detect_bypass |-> ##1 clock_loss_shutdown)
		else $error("no shutdown on clock loss");

	pwr_ratio_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		!clock_detect_bypass && ratio_r == acr_pkg::RATIO_NONE
		|=> !auto_power_up)
		else $error("power-up without ratio");

	mclk_rel_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		gap_r == 13'(RELEASE_CYC - 1) && !mclk_edge |=> !present_r)
		else $error("presence not released");

	ratio_det_a: assert property (
		@(posedge ref_clk) disable iff (reset)
		present_r && fs_edge && frame_r == 10'd400
		|=> ratio_r == acr_pkg::RATIO_400)
		else $error("ratio 400 missed");

endmodule : acr_top

// [verif/acr_src_model.sv]
// source model: master clock, bit clock and frame sync from ref_clk
// assumes ref_clk is the 125 MHz core clock of the bench
`timescale 1ns/1ps

module acr_src_model (
	input wire logic ref_clk, // core clock
	input wire logic run, // low stops every clock
	input wire logic [5:0] half, // ref_clk cycles per mclk half period
	input wire logic [9:0] mpf, // mclk periods per frame
	input wire logic [5:0] bpf, // bclk pulses per frame
	output logic mclk, // master clock
	output logic bclk, // bit clock
	output logic fsync // frame sync
);
	logic [5:0] ph_r = 6'h00;
	logic [9:0] cnt_r = 10'h000;
	logic mclk_r = 1'b0;

	// clocks and frame kept in range
	always_ff @(posedge ref_clk) begin
		if (run) begin
			if (ph_r + 6'h01 >= half) begin
				ph_r <= 6'h00;
				mclk_r <= ~mclk_r;
				if (mclk_r)
					cnt_r <= (cnt_r + 10'h001 >= mpf) ? 10'h000 : cnt_r + 10'h001;
			end else begin
				ph_r <= ph_r + 6'h01;
			end
		end
	end

	// clocks stand still low while stopped; bclk pulses open each frame
	assign mclk = mclk_r & run;
	assign bclk = mclk & (cnt_r < {4'h0, bpf});
	assign fsync = run & (cnt_r < (mpf >> 1));
endmodule : acr_src_model

// [verif/tb_top.sv]
// bench for acr_top: register calls and clock scenarios, self-checking
// assumes acr_src_model drives the clock pins
`timescale 1ns/1ps

module tb_top;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic run = 1'b0;
	logic clock_detect_bypass = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [9:0] mpf = 10'd256;
	logic [5:0] half = 6'd3;
	logic [5:0] bpf = 6'd32;
	logic mclk;
	logic bclk;
	logic fsync;
	logic [15:0] reg_rdata;
	logic [15:0] rd_v;
	logic auto_power_up;
	logic clock_loss_shutdown;
	acr_pkg::acr_stat_s status;
	logic [8:0] dac_osr;
	acr_pkg::acr_div_e dac_div;
	logic [2:0] rate_range;
	logic [3:0] sys_ticks;
	int fails = 0;
	int checks_done = 0;
	// per case: clkdiv value, mclk per frame, half period, bclks, results
	// legal cases land on 256, 400 or 500; case 9 is a bad ratio
	// the ratio 400 case programs the quarter dac divider
	logic [15:0] t_cfg [11] = '{16'h0011, 16'h0012, 16'h0111, 16'h0211,
		16'h0311, 16'h0411, 16'h0422, 16'h2011, 16'h0011, 16'h0011, 16'h0011};
	int t_mpf [11] = '{256, 512, 256, 128, 64, 32, 128, 400, 500, 300, 256};
	int t_half [11] = '{3, 3, 3, 6, 12, 25, 6, 3, 3, 3, 3};
	int t_bpf [11] = '{32, 32, 32, 32, 32, 16, 32, 32, 32, 32, 7};
	logic [1:0] t_rat [11] = '{1, 1, 1, 1, 1, 1, 1, 2, 3, 0, 1};
	logic t_pu [11] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0};
	logic [8:0] t_osr [11] = '{32, 32, 32, 32, 32, 32, 32, 100, 100, 32, 32};
	logic [2:0] t_div [11] = '{0, 0, 0, 0, 0, 0, 0, 2, 4, 0, 0};

	acr_src_model src_u (.ref_clk(ref_clk), .run(run), .half(half),
		.mpf(mpf), .bpf(bpf), .mclk(mclk), .bclk(bclk), .fsync(fsync));

	acr_top #(.RELEASE_CYC(200)) dut_u (.ref_clk(ref_clk), .reset(reset),
		.mclk(mclk), .bclk(bclk), .fsync(fsync),
		.clock_detect_bypass(clock_detect_bypass), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .auto_power_up(auto_power_up),
		.clock_loss_shutdown(clock_loss_shutdown), .status(status),
		.dac_osr(dac_osr), .dac_div(dac_div), .rate_range(rate_range),
		.sys_ticks(sys_ticks));

	// core clock, 8 ns period
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end

	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data is taken one edge after the strobe
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	task close_out;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		tick(3);
		chk("shutdown", 16'(clock_loss_shutdown), 16'h0001);
		rd(8'h03, rd_v);
		chk("clkdiv", rd_v, 16'h0011);
		rd(8'h29, rd_v);
		chk("osrsel", rd_v, 16'h0000);
		wr(8'h10, 16'hffff);
		rd(8'h10, rd_v);
		chk("unmapped", rd_v, 16'h0000);
		wr(8'h40, 16'hffff);
		rd(8'h40, rd_v);
		chk("srate", rd_v, 16'h0fff);
		chk("range", 16'(rate_range), 16'h0007);
		wr(8'h40, 16'h0002);
		// each case must land on its listed ratio; case 9 must land on none
		foreach (t_cfg[i]) begin
			wr(8'h03, t_cfg[i]);
			mpf <= 10'(t_mpf[i]);
			half <= 6'(t_half[i]);
			bpf <= 6'(t_bpf[i]);
			run <= 1'b1;
			tick(6 * t_mpf[i] * t_half[i]);
			chk("ratio", 16'(status.ratio), 16'(t_rat[i]));
			chk("power", 16'(auto_power_up), 16'(t_pu[i]));
			if (t_rat[i] != 2'h0) begin
				chk("osr", 16'(dac_osr), 16'(t_osr[i]));
				chk("div", 16'(dac_div), 16'(t_div[i]));
			end
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h29, 16'(i));
			tick(2);
			chk("osr", 16'(dac_osr), 16'(32 << i));
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h03, 16'h0011 | 16'(i << 12));
			tick(2);
			chk("div", 16'(dac_div), 16'(i));
		end
		clock_detect_bypass <= 1'b1;
		mpf <= 10'd500;
		tick(9000);
		chk("power", 16'(auto_power_up), 16'h0001);
		chk("ratio", 16'(status.ratio), 16'h0003);
		run <= 1'b0;
		tick(250);
		chk("present", 16'(status.master_clock_present), 16'h0000);
		chk("power", 16'(auto_power_up), 16'h0001);
		clock_detect_bypass <= 1'b0;
		tick(3);
		chk("shutdown", 16'(clock_loss_shutdown), 16'h0001);
		chk("power", 16'(auto_power_up), 16'h0000);
		run <= 1'b1;
		for (int k = 0; k < 150 && status.master_clock_present !== 1'b1; k++)
			tick(1);
		chk("present", 16'(status.master_clock_present), 16'h0001);
		// direct divide by one: each mclk rising edge gives one system tick
		for (int k = 0; k < 20 && sys_ticks === 4'h0; k++)
			tick(1);
		chk("ticks", 16'(sys_ticks), 16'h0001);
		close_out();
	end
endmodule : tb_top
